// >>> hw/sadm_decoder.sv
/*
 System address map decoder: steers each word of a processor access to one
 target and one core bus, serves bit-band alias and unaligned accesses
 by split or read-modify-write steps, and hands the external RAM window
 to the external memory port engine.
 Assumes targets answer with tgt_ready_i in the cycle their data is
 valid, and that requester and targets share sys_clk_i.
*/
`timescale 1ns/100ps
`include "sadm_cfg.svh"

module sadm_decoder (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [31:0] req_addr_i,
  input wire logic req_write_i,
  input wire logic [1:0] req_size_i,
  input wire logic req_fetch_i,
  input wire logic req_debug_i,
  input wire logic [31:0] req_wdata_i,
  output logic resp_valid_o,
  output logic resp_err_o,
  output logic [31:0] resp_rdata_o,
  output logic tgt_valid_o,
  input wire logic tgt_ready_i,
  output logic [9:0] tgt_sel_o,
  output sadm_pkg::sadm_bus_t tgt_bus_o,
  output logic [31:0] tgt_addr_o,
  output logic tgt_we_o,
  output logic [3:0] tgt_be_o,
  output logic [31:0] tgt_wdata_o,
  input wire logic [31:0] tgt_rdata_i,
  input wire logic ext_width16_i,
  input wire logic ext_sync_i,
  output logic [23:0] ext_addr_o,
  output logic [15:0] ext_data_o,
  output logic ext_data_oe_o,
  input wire logic [15:0] ext_data_i,
  output logic ext_cs_n_o,
  output logic ext_we_n_o,
  output logic ext_oe_n_o,
  output logic [1:0] ext_be_n_o,
  output logic ext_clk_o
);

  function automatic sadm_pkg::sadm_tgt_t tgt_of(input logic [31:0] a);
    sadm_pkg::sadm_tgt_t t;
    t = sadm_pkg::TGT_NONE;
    if (a <= `SADM_FLASH_END) t = sadm_pkg::TGT_FLASH;
    else if (a >= `SADM_SRAM_LO_BASE && a <= `SADM_SRAM_HI_END)
      t = sadm_pkg::TGT_SRAM;
    else if (a >= `SADM_CLK_BASE && a <= `SADM_CLK_END)
      t = sadm_pkg::TGT_CLOCK;
    else if (a >= `SADM_PWR_BASE && a <= `SADM_PWR_END)
      t = sadm_pkg::TGT_POWER;
    else if (a >= `SADM_EXTCTL_BASE && a <= `SADM_EXTCTL_END)
      t = sadm_pkg::TGT_EXTCTL;
    else if (a >= `SADM_RSV_BASE && a <= `SADM_RSV_END)
      t = sadm_pkg::TGT_NONE;
    else if (a >= `SADM_PERIPH_BASE && a <= `SADM_PERIPH_END)
      t = sadm_pkg::TGT_PERIPH;
    else if (a >= `SADM_EXTRAM_BASE && a <= `SADM_EXTMEM_END)
      t = sadm_pkg::TGT_EXTMEM;
    else if (a >= `SADM_EXTPER_BASE && a <= `SADM_EXTPER_END)
      t = sadm_pkg::TGT_EXTPER;
    else if (a >= `SADM_INTPER_BASE && a <= `SADM_PPB_END)
      t = sadm_pkg::TGT_PPB;
    else if (a >= `SADM_SYSHI_BASE)
      t = sadm_pkg::TGT_SYSHI;
    return t;
  endfunction

  function automatic sadm_pkg::sadm_bus_t bus_of(input logic [31:0] a,
                                                 input logic fetch);
    sadm_pkg::sadm_bus_t b;
    if (a <= `SADM_CODE_END)
      b = fetch ? sadm_pkg::BUS_ICODE : sadm_pkg::BUS_DCODE;
    else if (a >= `SADM_INTPER_BASE && a <= `SADM_PPB_END)
      b = sadm_pkg::BUS_PPB;
    else
      b = sadm_pkg::BUS_SYS;
    return b;
  endfunction

  function automatic logic [9:0] sel_of(input sadm_pkg::sadm_tgt_t t);
    logic [9:0] s;
    s = 10'h000;
    if (t != sadm_pkg::TGT_NONE) s = 10'h001 << (4'(t) - 4'h1);
    return s;
  endfunction

  sadm_pkg::sadm_state_t st_reg, st_next;
  sadm_pkg::sadm_tgt_t tgt_reg, tgt_next;
  sadm_pkg::sadm_bus_t bus_reg, bus_next;
  logic [31:0] cur_reg, cur_next;
  logic [1:0] off_reg, off_next, size_reg, size_next;
  logic we_reg, we_next, bb_reg, bb_next, bbw_reg, bbw_next;
  logic part_reg, part_next, fetch_reg, fetch_next, err_reg, err_next;
  logic [4:0] bit_reg, bit_next;
  logic [3:0] hi_be_reg, hi_be_next, obe_reg, obe_next;
  logic [31:0] hi_wd_reg, hi_wd_next, owd_reg, owd_next;
  logic owe_reg, owe_next;
  logic [31:0] rd_lo_reg, rd_lo_next, rdata_reg, rdata_next;
  logic [9:0] sel_reg, sel_next;
  logic in_alias, efetch, is_ext, ack, ext_done;
  logic [31:0] a0, rdin, ext_rdata, bbw_word;
  logic [7:0] be64;
  logic [63:0] wd64, rd64;
  logic [3:0] mask;

  assign is_ext = (tgt_reg == sadm_pkg::TGT_EXTMEM);
  assign ack = is_ext ? ext_done : tgt_ready_i;
  assign rdin = is_ext ? ext_rdata : tgt_rdata_i;

  always_comb begin
    st_next = st_reg;
    tgt_next = tgt_reg;
    bus_next = bus_reg;
    cur_next = cur_reg;
    off_next = off_reg;
    size_next = size_reg;
    we_next = we_reg;
    bb_next = bb_reg;
    bbw_next = bbw_reg;
    part_next = part_reg;
    fetch_next = fetch_reg;
    err_next = err_reg;
    bit_next = bit_reg;
    hi_be_next = hi_be_reg;
    hi_wd_next = hi_wd_reg;
    obe_next = obe_reg;
    owd_next = owd_reg;
    owe_next = owe_reg;
    rd_lo_next = rd_lo_reg;
    rdata_next = rdata_reg;
    in_alias = req_addr_i >= `SADM_ALIAS_BASE &&
               req_addr_i <= `SADM_ALIAS_END;
    efetch = req_fetch_i && !req_debug_i;
    a0 = in_alias ? (`SADM_SRAM_BASE | {12'h000, req_addr_i[24:7], 2'h0})
                  : {req_addr_i[31:2], 2'h0};
    mask = (req_size_i == 2'h0) ? 4'h1 : (req_size_i == 2'h1) ? 4'h3 : 4'hF;
    be64 = {4'h0, in_alias ? 4'hF : mask}
           << (in_alias ? 2'h0 : req_addr_i[1:0]);
    wd64 = {32'h0, req_wdata_i} << {req_addr_i[1:0], 3'h0};
    rd64 = part_reg ? {rdin, rd_lo_reg} : {32'h0, rdin};
    bbw_word = (rdin & ~(32'h1 << bit_reg)) |
               ({31'h0, owd_reg[0]} << bit_reg);
    case (st_reg)
      sadm_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          tgt_next = tgt_of(a0);
          bus_next = bus_of(a0, efetch);
          cur_next = a0;
          off_next = in_alias ? 2'h0 : req_addr_i[1:0];
          size_next = in_alias ? 2'h2 : req_size_i;
          we_next = req_write_i;
          bb_next = in_alias;
          bbw_next = 1'b0;
          part_next = 1'b0;
          fetch_next = efetch;
          bit_next = req_addr_i[6:2];
          hi_be_next = be64[7:4];
          hi_wd_next = wd64[63:32];
          obe_next = be64[3:0];
          owd_next = in_alias ? {31'h0, req_wdata_i[0]} : wd64[31:0];
          // Alias writes start with a read of the backing word
          owe_next = req_write_i && !in_alias;
          rdata_next = 32'h0;
          // Fetches only from code, SRAM, or a 16-bit external memory
          err_next = (tgt_of(a0) == sadm_pkg::TGT_NONE) ||
                     (efetch && !(a0 <= `SADM_SRAM_END ||
                      (tgt_of(a0) == sadm_pkg::TGT_EXTMEM &&
                       ext_width16_i)));
          st_next = err_next ? sadm_pkg::ST_RESP : sadm_pkg::ST_ACC;
        end
      end
      sadm_pkg::ST_ACC: begin
        if (ack) begin
          if (bb_reg && we_reg && !bbw_reg) begin
            bbw_next = 1'b1;
            owe_next = 1'b1;
            owd_next = bbw_word;
          end else if (!part_reg && hi_be_reg != 4'h0) begin
            // Second word of an unaligned access
            part_next = 1'b1;
            rd_lo_next = rdin;
            cur_next = cur_reg + 32'h4;
            tgt_next = tgt_of(cur_reg + 32'h4);
            bus_next = bus_of(cur_reg + 32'h4, fetch_reg);
            obe_next = hi_be_reg;
            owd_next = hi_wd_reg;
            if (tgt_of(cur_reg + 32'h4) == sadm_pkg::TGT_NONE) begin
              err_next = 1'b1;
              st_next = sadm_pkg::ST_RESP;
            end
          end else begin
            st_next = sadm_pkg::ST_RESP;
            if (we_reg) rdata_next = 32'h0;
            else if (bb_reg) rdata_next = {31'h0, rdin[bit_reg]};
            else begin
              rdata_next = 32'(rd64 >> {off_reg, 3'h0});
              if (size_reg == 2'h0) rdata_next[31:8] = 24'h0;
              else if (size_reg == 2'h1) rdata_next[31:16] = 16'h0;
            end
          end
        end
      end
      sadm_pkg::ST_RESP: st_next = sadm_pkg::ST_IDLE;
      default: st_next = sadm_pkg::ST_IDLE;
    endcase
    sel_next = sel_of(tgt_next);
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= sadm_pkg::ST_IDLE;
      tgt_reg <= sadm_pkg::TGT_NONE;
      bus_reg <= sadm_pkg::BUS_SYS;
      cur_reg <= 32'h0;
      off_reg <= 2'h0;
      size_reg <= 2'h0;
      we_reg <= 1'b0;
      bb_reg <= 1'b0;
      bbw_reg <= 1'b0;
      part_reg <= 1'b0;
      fetch_reg <= 1'b0;
      err_reg <= 1'b0;
      bit_reg <= 5'h0;
      hi_be_reg <= 4'h0;
      hi_wd_reg <= 32'h0;
      obe_reg <= 4'h0;
      owd_reg <= 32'h0;
      owe_reg <= 1'b0;
      rd_lo_reg <= 32'h0;
      rdata_reg <= 32'h0;
      sel_reg <= 10'h000;
    end else if (ce_i) begin
      st_reg <= st_next;
      tgt_reg <= tgt_next;
      bus_reg <= bus_next;
      cur_reg <= cur_next;
      off_reg <= off_next;
      size_reg <= size_next;
      we_reg <= we_next;
      bb_reg <= bb_next;
      bbw_reg <= bbw_next;
      part_reg <= part_next;
      fetch_reg <= fetch_next;
      err_reg <= err_next;
      bit_reg <= bit_next;
      hi_be_reg <= hi_be_next;
      hi_wd_reg <= hi_wd_next;
      obe_reg <= obe_next;
      owd_reg <= owd_next;
      owe_reg <= owe_next;
      rd_lo_reg <= rd_lo_next;
      rdata_reg <= rdata_next;
      sel_reg <= sel_next;
    end
  end

  assign req_ready_o = (st_reg == sadm_pkg::ST_IDLE);
  assign resp_valid_o = (st_reg == sadm_pkg::ST_RESP);
  assign resp_err_o = err_reg;
  assign resp_rdata_o = rdata_reg;
  assign tgt_valid_o = (st_reg == sadm_pkg::ST_ACC) && !is_ext;
  assign tgt_sel_o = sel_reg;
  assign tgt_bus_o = bus_reg;
  assign tgt_addr_o = cur_reg;
  assign tgt_we_o = owe_reg;
  assign tgt_be_o = obe_reg;
  assign tgt_wdata_o = owd_reg;

  // Window base has zero low bits, so the offset is the low 24 bits
  sadm_ext_port u_ext (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .valid_i(st_reg == sadm_pkg::ST_ACC && is_ext),
    .we_i(owe_reg),
    .addr_i(cur_reg[23:0]),
    .be_i(obe_reg),
    .wdata_i(owd_reg),
    .width16_i(ext_width16_i),
    .sync_i(ext_sync_i),
    .done_o(ext_done),
    .rdata_o(ext_rdata),
    .ext_addr_o(ext_addr_o),
    .ext_data_o(ext_data_o),
    .ext_data_oe_o(ext_data_oe_o),
    .ext_data_i(ext_data_i),
    .ext_cs_n_o(ext_cs_n_o),
    .ext_we_n_o(ext_we_n_o),
    .ext_oe_n_o(ext_oe_n_o),
    .ext_be_n_o(ext_be_n_o),
    .ext_clk_o(ext_clk_o)
  );

  default clocking dflt @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i || !ce_i);

  sequence s_bb_read_step;
    tgt_valid_o && tgt_ready_i && bb_reg && we_reg && !bbw_reg;
  endsequence
  sequence s_bb_write_step(logic [31:0] addr);
    tgt_valid_o && tgt_we_o && tgt_addr_o == addr && tgt_be_o == 4'hF;
  endsequence

  a_sel_onehot: assert property ($onehot0(tgt_sel_o))
    else $error("more than one target selected");
  a_none_on_rsv: assert property (tgt_valid_o |-> |tgt_sel_o)
    else $error("access issued with no target");
  a_code_bus: assert property (tgt_valid_o &&
    (tgt_bus_o == sadm_pkg::BUS_ICODE || tgt_bus_o == sadm_pkg::BUS_DCODE)
    |-> tgt_addr_o <= `SADM_CODE_END)
    else $error("code bus used outside code range");
  a_sys_bus: assert property (tgt_valid_o &&
    tgt_bus_o == sadm_pkg::BUS_SYS |-> tgt_addr_o >= `SADM_SRAM_BASE &&
    !(tgt_addr_o >= `SADM_INTPER_BASE && tgt_addr_o <= `SADM_PPB_END))
    else $error("system bus used outside its ranges");
  a_ppb_route: assert property (tgt_valid_o &&
    tgt_sel_o == sel_of(sadm_pkg::TGT_PPB) |-> tgt_bus_o == sadm_pkg::BUS_PPB)
    else $error("private peripheral not on its bus");
  a_vector_flash: assert property (tgt_valid_o &&
    tgt_addr_o == `SADM_CODE_BASE |-> tgt_sel_o == sel_of(sadm_pkg::TGT_FLASH))
    else $error("vector fetch not served by flash");
  a_sram_span: assert property (
    tgt_sel_o == sel_of(sadm_pkg::TGT_SRAM) && tgt_valid_o |->
    tgt_addr_o >= `SADM_SRAM_LO_BASE && tgt_addr_o <= `SADM_SRAM_HI_END)
    else $error("SRAM select outside its span");
  a_bb_rmw_seq: assert property (
    s_bb_read_step |=> s_bb_write_step($past(tgt_addr_o)))
    else $error("alias write not followed by word write-back");
  a_bb_read_bit: assert property (resp_valid_o && bb_reg && !we_reg
    |-> resp_rdata_o[31:1] == 31'h0)
    else $error("alias read returned more than one bit");
  a_ext_fetch_w: assert property ($rose(resp_valid_o) && fetch_reg &&
    tgt_reg == sadm_pkg::TGT_EXTMEM && !ext_width16_i |-> resp_err_o)
    else $error("fetch from 8-bit external memory accepted");

endmodule

// >>> hw/sadm_ext_port.sv
/*
 External memory port engine: splits one aligned word access into
 8- or 16-bit memory cycles of a fixed bus-clock length.
 Assumes the request fields stay stable while valid_i is high and
 that memory data is valid from the second cycle of each unit.
*/
`timescale 1ns/100ps
`include "sadm_cfg.svh"

module sadm_ext_port (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic valid_i,
  input wire logic we_i,
  input wire logic [23:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  input wire logic width16_i,
  input wire logic sync_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic [23:0] ext_addr_o,
  output logic [15:0] ext_data_o,
  output logic ext_data_oe_o,
  input wire logic [15:0] ext_data_i,
  output logic ext_cs_n_o,
  output logic ext_we_n_o,
  output logic ext_oe_n_o,
  output logic [1:0] ext_be_n_o,
  output logic ext_clk_o
);

  localparam logic [1:0] PH_LAST = 2'(`SADM_EXT_ACC_CLKS - 1);

  sadm_pkg::sadm_ext_state_t st_reg, st_next;
  logic [1:0] ph_reg, ph_next, unit_reg, unit_next;
  logic done_reg, done_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] din_s1_reg, din_s2_reg;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] data_reg, data_next;
  logic doe_reg, doe_next, cs_n_reg, cs_n_next;
  logic we_n_reg, we_n_next, oe_n_reg, oe_n_next, clk_reg, clk_next;
  logic [1:0] be_n_reg, be_n_next, lane_en;
  logic busy;

  always_comb begin
    st_next = st_reg;
    ph_next = ph_reg;
    unit_next = unit_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    case (st_reg)
      sadm_pkg::EX_IDLE: begin
        // Done cycle blocks a repeat start on the same request
        if (valid_i && !done_reg) begin
          st_next = sadm_pkg::EX_BUSY;
          ph_next = 2'h0;
          unit_next = 2'h0;
          rdata_next = 32'h0;
        end
      end
      sadm_pkg::EX_BUSY: begin
        ph_next = ph_reg + 2'h1;
        if (ph_reg == PH_LAST) begin
          if (width16_i) begin
            rdata_next[{unit_reg[0], 4'h0} +: 16] = din_s2_reg;
          end else begin
            rdata_next[{unit_reg, 3'h0} +: 8] = din_s2_reg[7:0];
          end
          if (unit_reg == (width16_i ? 2'h1 : 2'h3)) begin
            st_next = sadm_pkg::EX_IDLE;
            done_next = 1'b1;
          end else begin
            unit_next = unit_reg + 2'h1;
          end
        end
      end
      default: st_next = sadm_pkg::EX_IDLE;
    endcase
    busy = (st_next == sadm_pkg::EX_BUSY);
    lane_en = width16_i ? be_i[{unit_next[0], 1'b0} +: 2]
                        : {1'b0, be_i[unit_next]};
    addr_next = width16_i ? addr_i + {21'h0, unit_next, 1'b0}
                          : addr_i + {22'h0, unit_next};
    data_next = width16_i ? wdata_i[{unit_next[0], 4'h0} +: 16]
                          : {8'h00, wdata_i[{unit_next, 3'h0} +: 8]};
    cs_n_next = ~busy;
    we_n_next = ~(busy && we_i && ph_next != 2'h0 && |lane_en);
    oe_n_next = ~(busy && !we_i && ph_next != 2'h0);
    doe_next = busy && we_i;
    be_n_next = ~lane_en;
    // Async memories see no clock at all
    clk_next = sync_i && busy && ph_next[1];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= sadm_pkg::EX_IDLE;
      ph_reg <= 2'h0;
      unit_reg <= 2'h0;
      done_reg <= 1'b0;
      rdata_reg <= 32'h0;
      din_s1_reg <= 16'h0;
      din_s2_reg <= 16'h0;
      addr_reg <= 24'h0;
      data_reg <= 16'h0;
      doe_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      be_n_reg <= 2'h3;
      clk_reg <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      unit_reg <= unit_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      din_s1_reg <= ext_data_i;
      din_s2_reg <= din_s1_reg;
      addr_reg <= addr_next;
      data_reg <= data_next;
      doe_reg <= doe_next;
      cs_n_reg <= cs_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      be_n_reg <= be_n_next;
      clk_reg <= clk_next;
    end
  end

  assign done_o = done_reg;
  assign rdata_o = rdata_reg;
  assign ext_addr_o = addr_reg;
  assign ext_data_o = data_reg;
  assign ext_data_oe_o = doe_reg;
  assign ext_cs_n_o = cs_n_reg;
  assign ext_we_n_o = we_n_reg;
  assign ext_oe_n_o = oe_n_reg;
  assign ext_be_n_o = be_n_reg;
  assign ext_clk_o = clk_reg;

  logic [4:0] cs_cnt;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_cnt <= 5'h0;
    end else if (ce_i) begin
      cs_cnt <= ext_cs_n_o ? 5'h0 : cs_cnt + 5'h1;
    end
  end

  a_ext_cycle_len: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i || !ce_i)
    $rose(ext_cs_n_o) |-> ($past(cs_cnt) == 5'h07 ||
      $past(cs_cnt) == 5'h0F))
    else $error("external access not a whole number of 4-cycle units");

  a_ext_async_clk: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i || !ce_i)
    ext_clk_o |-> $past(sync_i))
    else $error("memory clock toggled in async mode");

endmodule

// >>> inc/sadm_cfg.svh
/*
 Address map and external memory port constants for the system
 address map decoder. Assumes a 32-bit byte address and one bus clock.
*/
`ifndef SADM_CFG_SVH
`define SADM_CFG_SVH

`define SADM_CODE_BASE 32'h00000000
`define SADM_CODE_END 32'h1FFFFFFF
`define SADM_FLASH_END 32'h0003FFFF
`define SADM_SRAM_LO_BASE 32'h1FFF8000
`define SADM_SRAM_BASE 32'h20000000
`define SADM_SRAM_HI_END 32'h20007FFF
`define SADM_ALIAS_BASE 32'h22000000
`define SADM_ALIAS_END 32'h23FFFFFF
`define SADM_SRAM_END 32'h3FFFFFFF
`define SADM_PERIPH_BASE 32'h40000000
`define SADM_PERIPH_END 32'h5FFFFFFF
`define SADM_CLK_BASE 32'h40004000
`define SADM_CLK_END 32'h400042FF
`define SADM_PWR_BASE 32'h40004300
`define SADM_PWR_END 32'h400043FF
`define SADM_EXTCTL_BASE 32'h40005400
`define SADM_EXTCTL_END 32'h400054FF
`define SADM_RSV_BASE 32'h4000A000
`define SADM_RSV_END 32'h4000A400
`define SADM_EXTRAM_BASE 32'h60000000
`define SADM_EXTMEM_END 32'h60FFFFFF
`define SADM_EXTPER_BASE 32'hA0000000
`define SADM_EXTPER_END 32'hDFFFFFFF
`define SADM_INTPER_BASE 32'hE0000000
`define SADM_PPB_END 32'hE00FFFFF
`define SADM_SYSHI_BASE 32'hE0100000

`define SADM_SEL_W 10
`define SADM_EXT_ADDR_W 24
`define SADM_EXT_DATA_W 16
`define SADM_EXT_ACC_CLKS 4

`endif

// >>> inc/sadm_pkg.sv
/*
 Types for the system address map decoder: targets, buses and states.
 Assumes the constants header is compiled alongside.
*/
package sadm_pkg;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_FLASH, TGT_SRAM, TGT_CLOCK, TGT_POWER, TGT_EXTCTL,
    TGT_PERIPH, TGT_EXTMEM, TGT_EXTPER, TGT_PPB, TGT_SYSHI
  } sadm_tgt_t;

  typedef enum logic [1:0] {
    BUS_ICODE, BUS_DCODE, BUS_SYS, BUS_PPB
  } sadm_bus_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_RESP} sadm_state_t;

  typedef enum logic {EX_IDLE, EX_BUSY} sadm_ext_state_t;

endpackage

// >>> sim/sadm_tgt_model.sv
/*
 Far-side model: one word memory shared by every on-chip target, and an
 external memory whose byte at address a reads back a[7:0].
 Assumes the decoder's clock; slow_i changes only between accesses.
*/
`timescale 1ns/100ps
module sadm_tgt_model (
  input wire logic sys_clk_i,
  input wire logic slow_i,
  input wire logic tgt_valid_i,
  input wire logic tgt_we_i,
  input wire logic [3:0] tgt_be_i,
  input wire logic [31:0] tgt_addr_i,
  input wire logic [31:0] tgt_wdata_i,
  output logic tgt_ready_o,
  output logic [31:0] tgt_rdata_o,
  input wire logic [23:0] ext_addr_i,
  input wire logic ext_oe_n_i,
  output logic [15:0] ext_data_o
);
  logic [31:0] mem [256];
  logic wait_reg = 1'h0;
  logic [15:0] last = 16'h0;
  initial foreach (mem[i]) mem[i] = 32'h0;
  // Slow mode holds each part for one extra cycle
  assign tgt_ready_o = tgt_valid_i && (!slow_i || wait_reg);
  // Junk outside the ready cycle, so stale data cannot pass
  assign tgt_rdata_o = tgt_ready_o ? mem[tgt_addr_i[9:2]] :
                       ~mem[tgt_addr_i[9:2]];
  assign ext_data_o = ext_oe_n_i ? ~last :
                      {ext_addr_i[7:0] + 8'h01, ext_addr_i[7:0]};
  always @(posedge sys_clk_i) begin
    wait_reg <= tgt_valid_i && !wait_reg && slow_i;
    if (!ext_oe_n_i) last <= ext_data_o;
    if (tgt_ready_o && tgt_we_i)
      for (int i = 0; i < 4; i++)
        if (tgt_be_i[i]) mem[tgt_addr_i[9:2]][8*i+:8] <= tgt_wdata_i[8*i+:8];
  end
endmodule

// >>> sim/system_address_map_decoder_test.sv
/*
 Self-checking bench for the address map decoder.
 Assumes the far-side model stands in for all memories and peripherals.
*/
`timescale 1ns/100ps
module system_address_map_decoder_test;
  logic sys_clk_i = 1'h0, arst_n_i = 1'h0, req_valid_i = 1'h0;
  logic req_write_i = 1'h0, req_fetch_i = 1'h0, slow = 1'h0;
  logic ext_width16_i = 1'h1, ext_sync_i = 1'h1, req_ready_o;
  logic resp_valid_o, resp_err_o, tgt_valid_o, tgt_ready_i, tgt_we_o;
  logic ext_cs_n_o, ext_oe_n_o, ext_we_n_o, ext_clk_o, ext_data_oe_o;
  logic req_debug_i = 1'h0;
  logic [1:0] req_size_i = 2'h2;
  logic [3:0] tgt_be_o;
  logic [9:0] tgt_sel_o, seen;
  logic [15:0] ext_data_i, ext_data_o, wlast;
  logic [23:0] ext_addr_o;
  logic [31:0] req_addr_i = 32'h0, req_wdata_i = 32'h0, st = 32'h2D;
  logic [31:0] resp_rdata_o, tgt_addr_o, tgt_wdata_o, tgt_rdata_i;
  logic [31:0] a, x, y, z;
  sadm_pkg::sadm_bus_t tgt_bus_o, bus;
  int n_errors = 0, comparisons = 0, cs_cycles = 0;
  int we_cycles = 0, clk_cycles = 0, oe_cycles = 0;
  // Address, then {fetch, expected select bit (A = none), bus}
  logic [31:0] ta [18] = '{32'h0, 32'h4, 32'h1FFF8000, 32'h20007FFC,
    32'h20000000, 32'h400042FC, 32'h40004300, 32'h400054FC, 32'h40005500,
    32'h4000A000, 32'h60000000, 32'h61000000, 32'hA0000000, 32'hE00FFFFC,
    32'hE0100000, 32'h40000000, 32'h40000, 32'h20008000};
  logic [6:0] tc [18] = '{7'h40, 7'h01, 7'h05, 7'h06, 7'h46, 7'h0A, 7'h0E,
    7'h12, 7'h16, 7'h28, 7'h1A, 7'h28, 7'h1E, 7'h23, 7'h26, 7'h68, 7'h28,
    7'h28};

  sadm_decoder u_sadm_decoder (.sys_clk_i, .arst_n_i, .ce_i(1'h1),
    .req_valid_i, .req_ready_o, .req_addr_i, .req_write_i, .req_size_i,
    .req_fetch_i, .req_debug_i, .req_wdata_i, .resp_valid_o,
    .resp_err_o, .resp_rdata_o, .tgt_valid_o, .tgt_ready_i, .tgt_sel_o,
    .tgt_bus_o, .tgt_addr_o, .tgt_we_o, .tgt_be_o, .tgt_wdata_o,
    .tgt_rdata_i, .ext_width16_i, .ext_sync_i, .ext_addr_o, .ext_data_o,
    .ext_data_oe_o, .ext_data_i, .ext_cs_n_o, .ext_we_n_o, .ext_oe_n_o,
    .ext_be_n_o(), .ext_clk_o);
  sadm_tgt_model u_sadm_tgt_model (.sys_clk_i, .slow_i(slow),
    .tgt_valid_i(tgt_valid_o), .tgt_we_i(tgt_we_o), .tgt_be_i(tgt_be_o),
    .tgt_addr_i(tgt_addr_o), .tgt_wdata_i(tgt_wdata_o),
    .tgt_ready_o(tgt_ready_i), .tgt_rdata_o(tgt_rdata_i),
    .ext_addr_i(ext_addr_o), .ext_oe_n_i(ext_oe_n_o),
    .ext_data_o(ext_data_i));

  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (tgt_valid_o) begin
      seen <= tgt_sel_o;
      bus <= tgt_bus_o;
    end
    if (!ext_cs_n_o) begin
      seen <= tgt_sel_o;
      cs_cycles <= cs_cycles + 1;
    end
    if (!ext_we_n_o) begin
      wlast <= ext_data_o;
      we_cycles <= we_cycles + 1;
    end
    if (ext_clk_o) clk_cycles <= clk_cycles + 1;
    if (ext_data_oe_o) oe_cycles <= oe_cycles + 1;
  end

  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  function automatic logic [31:0] ext_word(input logic [31:0] ad);
    return {ad[7:0] + 8'h03, ad[7:0] + 8'h02, ad[7:0] + 8'h01, ad[7:0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task test_done();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Taken at the next rising edge, since the decoder idles between calls
  task automatic acc(input logic [31:0] ad, input logic w, f,
                     input logic [31:0] d);
    @(negedge sys_clk_i);
    chk(req_ready_o, 1'h1);
    {req_addr_i, req_write_i, req_fetch_i, req_wdata_i} = {ad, w, f, d};
    slow = st[0];
    seen = 10'h0;
    cs_cycles = 0;
    {we_cycles, clk_cycles, oe_cycles} = '0;
    req_valid_i = 1'h1;
    @(negedge sys_clk_i);
    req_valid_i = 1'h0;
    for (int i = 0; i < 60 && resp_valid_o !== 1'h1; i++)
      @(negedge sys_clk_i);
    chk(resp_valid_o, 1'h1);
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    chk(tgt_sel_o, 10'h0);
    @(negedge sys_clk_i) arst_n_i = 1'h1;
    foreach (ta[i]) begin
      acc(ta[i], 1'h0, tc[i][6], 32'h0);
      chk(seen, tc[i][5:2] == 4'hA ? 10'h0 : 10'h1 << tc[i][5:2]);
      chk(resp_err_o, tc[i][5:2] == 4'hA);
      if (!(tc[i][5:2] inside {4'h6, 4'hA})) chk(bus, tc[i][1:0]);
    end
    // Debug access with the fetch flag set acts as data
    req_debug_i = 1'h1;
    acc(32'h40000000, 1'h0, 1'h1, 32'h0);
    chk(resp_err_o, 1'h0);
    chk(seen, 10'h1 << 5);
    chk(bus, 32'h2);
    req_debug_i = 1'h0;
    for (int m = 0; m < 4; m++) begin
      {ext_sync_i, ext_width16_i} = m[1:0];
      a = 32'h60000000 | (rnd() & 32'h00FFFFFC);
      acc(a, 1'h0, 1'h0, 32'h0);
      chk(resp_rdata_o, ext_word(a));
      chk(cs_cycles, m[0] ? 8 : 16);
      chk(clk_cycles, m[1] ? (m[0] ? 4 : 8) : 0);
      acc(a, 1'h0, 1'h1, 32'h0);
      chk(resp_err_o, !m[0]);
      x = rnd();
      acc(a, 1'h1, 1'h0, x);
      chk(we_cycles, m[0] ? 6 : 12);
      chk(oe_cycles, m[0] ? 8 : 16);
      chk(wlast, m[0] ? x[31:16] : {8'h00, x[31:24]});
    end
    repeat (6) begin
      a = 32'h20000000 | (rnd() & 32'h000003FC);
      x = rnd();
      acc(a, 1'h1, 1'h0, x);
      acc(a, 1'h0, 1'h0, 32'h0);
      chk(resp_rdata_o, x);
    end
    x = rnd();
    acc(32'h20000000, 1'h1, 1'h0, x);
    // Upper write bits set to show they are ignored
    acc(32'h2200000C, 1'h1, 1'h0, {31'h7FFFFFFF, ~x[3]});
    acc(32'h20000000, 1'h0, 1'h0, 32'h0);
    chk(resp_rdata_o, x ^ 32'h8);
    acc(32'h2200000C, 1'h0, 1'h0, 32'h0);
    chk(resp_rdata_o, {31'h0, ~x[3]});
    x = rnd();
    y = rnd();
    z = rnd();
    acc(32'h20000010, 1'h1, 1'h0, x);
    acc(32'h20000014, 1'h1, 1'h0, y);
    acc(32'h20000012, 1'h0, 1'h0, 32'h0);
    chk(resp_rdata_o, {y[15:0], x[31:16]});
    acc(32'h20000011, 1'h1, 1'h0, z);
    acc(32'h20000014, 1'h0, 1'h0, 32'h0);
    chk(resp_rdata_o, {y[31:8], z[31:24]});
    // Word straddling the two SRAM halves
    acc(32'h1FFFFFFE, 1'h1, 1'h0, x);
    acc(32'h1FFFFFFE, 1'h0, 1'h0, 32'h0);
    chk(resp_rdata_o, x);
    req_size_i = 2'h1;
    acc(32'h20000013, 1'h0, 1'h0, 32'h0);
    chk(resp_rdata_o, {16'h0, z[31:16]});
    test_done();
  end
endmodule
